/* dv/beac_host.sv */
// Host model: a classic Wishbone master standing in for the fieldbus controller.
// Assumes one clock shared with the counter; each read notes its expected word in a queue.
`timescale 1ns/100ps
module beac_host (
    input  wire logic        clk_i,
    input  wire logic        wb_ack_i,
    output logic      [7:0]  wb_adr_o,
    output logic      [31:0] wb_dat_o,
    output logic      [3:0]  wb_sel_o,
    output logic             wb_we_o,
    output logic             wb_cyc_o,
    output logic             wb_stb_o
);
    // Pending reads, oldest first: address above the expected word.
    logic [39:0] note_q[$];

    // The bus idles from time zero, so nothing is taken during reset.
    initial
    begin
        wb_adr_o = '0;
        wb_dat_o = '0;
        wb_sel_o = '0;
        wb_we_o  = 1'b0;
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
    end

    // One classic cycle; the request stands unchanged until ack is sampled high.
    // Starting on a fresh edge leaves cyc low for a cycle between requests.
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge clk_i);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o  <= we;
        wb_adr_o <= adr;
        wb_dat_o <= dat;
        wb_sel_o <= 4'hf;
        if (!we)
            note_q.push_back({adr, dat});
        do @(posedge clk_i); while (wb_ack_i !== 1'b1);
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
    endtask
endmodule

/* dv/beac_top_bench.sv */
// Self-checking bench for the encoder axis counter.
// Assumes the host model drives the register bus; pins are driven here at the rising edge.
`timescale 1ns/100ps
`define CHK(n, e, g) cmp(n, e, g)
module beac_top_bench;
    import beac_pkg::*;
    logic        clk_i, rst_i, pulse_pin_i, dir_pin_i, axis_fault_i;
    logic [3:0]  gate_input_pin_i, wb_sel_i;
    logic [1:0]  probe_pin_i;
    logic [7:0]  wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, n;
    logic        wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, irq_o;
    logic [39:0] note;
    int          failures = 0;
    int          checks   = 0;
    int          cycles   = 0;
    integer      seed     = 32'h00bc_d69e;

    beac_top #(.GATES(4)) u_beac_top (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .pulse_pin_i(pulse_pin_i), .dir_pin_i(dir_pin_i), .gate_input_pin_i(gate_input_pin_i),
        .probe_pin_i(probe_pin_i), .axis_fault_i(axis_fault_i), .irq_o(irq_o));
    beac_host u_beac_host (.clk_i(clk_i), .wb_ack_i(wb_ack_o), .wb_adr_o(wb_adr_i),
        .wb_dat_o(wb_dat_i), .wb_sel_o(wb_sel_i), .wb_we_o(wb_we_i), .wb_cyc_o(wb_cyc_i),
        .wb_stb_o(wb_stb_i));

    // Free-running 20 MHz clock.
    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // A hang is cut short well beyond the fewer than one thousand cycles the run needs.
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures++;
            complete_run();
        end
    end

    // Each read ack takes the oldest note off the host queue and compares the word.
    always @(posedge clk_i)
    begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && u_beac_host.note_q.size() > 0)
        begin
            note = u_beac_host.note_q.pop_front();
            `CHK($sformatf("reg %h", note[39:32]), note[31:0], wb_dat_o);
        end
    end

    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_beac_host.xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        u_beac_host.xfer(1'b0, a, e);
    endtask

    // Pulses last four cycles each way; the settle time lets pin changes pass the synchroniser.
    task automatic step(input logic [31:0] k);
        tick(6);
        repeat (k)
        begin
            pulse_pin_i <= 1'b1;
            tick(4);
            pulse_pin_i <= 1'b0;
            tick(4);
        end
        tick(8);
    endtask

    // Status word with bring-up done: axis code and the three low flag bits.
    function automatic logic [31:0] st(input logic [2:0] a, input logic [2:0] low);
        return {21'h0, STEP_READY, 1'b0, a, 1'b0, low};
    endfunction

    // Main sequence.
    initial
    begin
        rst_i = 1'b1;
        pulse_pin_i = 1'b0;
        dir_pin_i = 1'b0;
        axis_fault_i = 1'b0;
        gate_input_pin_i = 4'h0;
        probe_pin_i = 2'b00;
        tick(16);
        rst_i <= 1'b0;
        rd(OFF_CTRL, 32'h0000_0000);
        rd(OFF_STATUS, 32'h0000_0100);
        rd(OFF_LOWER, LOWER_RST);
        rd(OFF_UPPER, UPPER_RST);
        rd(OFF_PERIOD, PERIOD_RST);
        rd(OFF_GEAR, GEAR_RST);
        rd(OFF_P1_RISE, 32'h0000_0000);
        rd(OFF_P2_FALL, 32'h0000_0000);
        wr(OFF_RAW, 32'h0000_1234);
        rd(OFF_RAW, 32'h0000_0000);
        rd(8'h40, 32'h0000_0000);
        tick(110);
        rd(OFF_STATUS, st(AXIS_STOP, 3'h0));
        step(2);
        rd(OFF_RAW, 32'h0000_0000);
        wr(OFF_CTRL, 32'h0000_0301);
        step(2);
        rd(OFF_RAW, 32'h0000_0000);
        gate_input_pin_i <= 4'h1;
        step(2);
        rd(OFF_RAW, 32'h0000_0000);
        gate_input_pin_i <= 4'h3;
        n = ({$random(seed)} % 32'd8) + 32'd1;
        tick(6);
        rd(OFF_STATUS, st(AXIS_RUN, 3'h0));
        step(n);
        rd(OFF_RAW, n);
        wr(OFF_GEAR, 32'h0002_0000);
        rd(OFF_SCALED, n << 1);
        wr(OFF_IRQ_MASK, 32'h0000_0001);
        probe_pin_i <= 2'b01;
        tick(8);
        rd(OFF_P1_RISE, n);
        `CHK("irq raised", 32'h1, {31'h0, irq_o});
        step(1);
        probe_pin_i <= 2'b11;
        tick(8);
        rd(OFF_P2_RISE, n + 1);
        step(1);
        probe_pin_i <= 2'b00;
        tick(8);
        rd(OFF_P1_FALL, n + 2);
        rd(OFF_P2_FALL, n + 2);
        rd(OFF_IRQ_STAT, 32'h0000_000f);
        wr(OFF_IRQ_STAT, 32'h0000_000f);
        tick(2);
        `CHK("irq cleared", 32'h0, {31'h0, irq_o});
        dir_pin_i <= 1'b1;
        step(3);
        rd(OFF_RAW, n - 1);
        rd(OFF_STATUS, st(AXIS_RUN, 3'h1));
        wr(OFF_UPPER, n + 1);
        wr(OFF_CTRL, 32'h0000_0305);
        dir_pin_i <= 1'b0;
        step(4);
        rd(OFF_RAW, n + 1);
        rd(OFF_STATUS, st(AXIS_RUN, 3'h2));
        wr(OFF_LOWER, n - 1);
        dir_pin_i <= 1'b1;
        step(4);
        rd(OFF_RAW, n - 1);
        rd(OFF_STATUS, st(AXIS_RUN, 3'h5));
        // Both limit arrivals since the probe clear must have left their sticky bits.
        rd(OFF_IRQ_STAT, 32'h0000_0030);
        axis_fault_i <= 1'b1;
        tick(6);
        rd(OFF_STATUS, st(AXIS_FAULT, 3'h5));
        axis_fault_i <= 1'b0;
        rst_i <= 1'b1;
        tick(16);
        rst_i <= 1'b0;
        // A reset in mid-run must bring the count and the bring-up step back.
        rd(OFF_RAW, 32'h0000_0000);
        rd(OFF_STATUS, 32'h0000_0100);
        tick(110);
        wr(OFF_PERIOD, 32'h0000_0003);
        wr(OFF_CTRL, 32'h0000_0303);
        dir_pin_i <= 1'b0;
        step(5);
        rd(OFF_RAW, 32'h0000_0002);
        dir_pin_i <= 1'b1;
        step(4);
        rd(OFF_RAW, 32'h0000_0001);
        // Let the checker take the last note before the run ends.
        tick(2);
        complete_run();
    end
endmodule

/* rtl/beac_pkg.sv */
// Shared constants for the encoder axis counter: register map, field positions,
// reset values, status codes and timing.
// Assumes a 20 MHz single clock and a 32-bit classic Wishbone register bus.
// Behaviour
// - Mode 0 linear between limits, 1 ring.
// - Enable off holds count, on counts.
// - Direction bit low forward, high reverse.
// - Positive limit flag set at upper limit.
// - Negative limit flag set at lower limit.
// - Axis code 0 stopped, 1 fault, 5 running.
// - Bring-up code steps 1 to 6 in order.
// - Each probe latches count on both edges.
// - Report raw count and gear-scaled position.
// - Inactive selected gate input blocks counting.
// - Without limits count wraps over 32 bits.
// - All selected gates active before counting.
package beac_pkg;
    localparam int unsigned CNT_W         = 32;
    localparam int unsigned ADR_W         = 8;
    localparam int unsigned EV_W          = 6;
    // Register byte offsets.
    localparam logic [7:0]  OFF_CTRL      = 8'h00;
    localparam logic [7:0]  OFF_STATUS    = 8'h04;
    localparam logic [7:0]  OFF_LOWER     = 8'h08;
    localparam logic [7:0]  OFF_UPPER     = 8'h0c;
    localparam logic [7:0]  OFF_PERIOD    = 8'h10;
    localparam logic [7:0]  OFF_GEAR      = 8'h14;
    localparam logic [7:0]  OFF_RAW       = 8'h18;
    localparam logic [7:0]  OFF_SCALED    = 8'h1c;
    localparam logic [7:0]  OFF_P1_RISE   = 8'h20;
    localparam logic [7:0]  OFF_P2_RISE   = 8'h24;
    localparam logic [7:0]  OFF_P1_FALL   = 8'h28;
    localparam logic [7:0]  OFF_P2_FALL   = 8'h2c;
    localparam logic [7:0]  OFF_IRQ_STAT  = 8'h30;
    localparam logic [7:0]  OFF_IRQ_MASK  = 8'h34;
    // Control register fields.
    localparam int unsigned CTRL_EN_BIT   = 0;
    localparam int unsigned CTRL_RING_BIT = 1;
    localparam int unsigned CTRL_LIM_BIT  = 2;
    localparam int unsigned CTRL_GATE_LSB = 8;
    // Status register fields.
    localparam int unsigned ST_DIR_BIT    = 0;
    localparam int unsigned ST_PLIM_BIT   = 1;
    localparam int unsigned ST_NLIM_BIT   = 2;
    localparam int unsigned ST_AXIS_LSB   = 4;
    localparam int unsigned ST_STEP_LSB   = 8;
    // Interrupt event positions.
    localparam int unsigned EV_P1_RISE    = 0;
    localparam int unsigned EV_P2_RISE    = 1;
    localparam int unsigned EV_P1_FALL    = 2;
    localparam int unsigned EV_P2_FALL    = 3;
    localparam int unsigned EV_PLIM       = 4;
    localparam int unsigned EV_NLIM       = 5;
    // Axis condition codes and bring-up step codes.
    localparam logic [2:0]  AXIS_STOP     = 3'h0;
    localparam logic [2:0]  AXIS_FAULT    = 3'h1;
    localparam logic [2:0]  AXIS_RUN      = 3'h5;
    localparam logic [2:0]  STEP_INIT     = 3'h1;
    localparam logic [2:0]  STEP_READY    = 3'h6;
    // Reset values; the gear factor is signed fixed point with GEAR_FRAC fraction bits.
    localparam int unsigned GEAR_FRAC     = 16;
    localparam logic [31:0] GEAR_RST      = 32'h0001_0000;
    localparam logic [31:0] LOWER_RST     = 32'h8000_0000;
    localparam logic [31:0] UPPER_RST     = 32'h7fff_ffff;
    localparam logic [31:0] PERIOD_RST    = 32'h0000_0e10;
    localparam logic [31:0] CNT_MAX       = 32'h7fff_ffff;
    localparam logic [31:0] CNT_MIN       = 32'h8000_0000;
    // Dwell time of each bring-up step, as a least time rounded up to cycles.
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned STEP_TIME_NS  = 1000;
    localparam int unsigned STEP_CYC      = (STEP_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned STEP_CW       = 8;
endpackage

/* rtl/beac_probe.sv */
// One touch probe: latches the count on rising and on falling edges of its level.
// Assumes a level that is already synchronised to clk_i.
`timescale 1ns/100ps
module beac_probe
    import beac_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             level_i,
    input  wire logic [CNT_W-1:0] count_i,
    output logic      [CNT_W-1:0] rise_latch_o,
    output logic      [CNT_W-1:0] fall_latch_o,
    output logic                  rise_ev_o,
    output logic                  fall_ev_o
);
    logic             prev_q;
    logic [CNT_W-1:0] rise_d;
    logic [CNT_W-1:0] fall_d;

    // Edges are seen against the previous sample, so each edge captures once.
    always_comb
    begin
        rise_ev_o = level_i & ~prev_q;
        fall_ev_o = ~level_i & prev_q;
        rise_d    = rise_ev_o ? count_i : rise_latch_o;
        fall_d    = fall_ev_o ? count_i : fall_latch_o;
    end

    // Latches clear on reset.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            prev_q       <= 1'b0;
            rise_latch_o <= '0;
            fall_latch_o <= '0;
        end
        else
        begin
            prev_q       <= level_i;
            rise_latch_o <= rise_d;
            fall_latch_o <= fall_d;
        end
    end
endmodule

/* rtl/beac_sync.sv */
// Three-stage input synchroniser for a vector of pins.
// Assumes asynchronous pins; the output only follows once stages two and three agree.
`timescale 1ns/100ps
module beac_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] level_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] level_d;

    // The filtered level moves only when the two settled stages match.
    always_comb
    begin
        level_d = level_o;
        for (int i = 0; i < W; i++)
        begin
            if (s2_q[i] == s3_q[i])
            begin
                level_d[i] = s3_q[i];
            end
        end
    end

    // First stage feeds only the second, to keep metastability contained.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s1_q    <= '0;
            s2_q    <= '0;
            s3_q    <= '0;
            level_o <= '0;
        end
        else
        begin
            s1_q    <= pin_i;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            level_o <= level_d;
        end
    end
endmodule

/* rtl/beac_top.sv */
// Encoder axis counter with a classic Wishbone register slave and one interrupt.
// Assumes pulse, direction, gate, probe and fault pins asynchronous to clk_i.
`timescale 1ns/100ps
module beac_top
    import beac_pkg::*;
#(
    parameter int unsigned GATES = 4
) (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic [beac_pkg::ADR_W-1:0] wb_adr_i,
    input  wire logic [31:0]              wb_dat_i,
    input  wire logic [3:0]               wb_sel_i,
    input  wire logic                     wb_we_i,
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    output logic      [31:0]              wb_dat_o,
    output logic                          wb_ack_o,
    input  wire logic                     pulse_pin_i,
    input  wire logic                     dir_pin_i,
    input  wire logic [GATES-1:0]         gate_input_pin_i,
    input  wire logic [1:0]               probe_pin_i,
    input  wire logic                     axis_fault_i,
    output logic                          irq_o
);
    import beac_pkg::*;

    localparam int unsigned NSYNC = GATES + 5;

    // Gate selection must fit in the control word above its lowest field.
    if (GATES < 1 || GATES > 8)
    begin : g_bad_gates
        $error("GATES must be between 1 and 8");
    end

    logic [NSYNC-1:0]       sync_lvl;
    logic                   pulse_s;
    logic                   dir_s;
    logic [GATES-1:0]       gate_s;
    logic [1:0]             probe_s;
    logic                   fault_s;
    logic                   pulse_prev_q;

    // All pins pass the synchroniser before any logic sees them.
    beac_sync #(.W(NSYNC)) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   ({axis_fault_i, probe_pin_i, gate_input_pin_i, dir_pin_i, pulse_pin_i}),
        .level_o (sync_lvl)
    );
    assign {fault_s, probe_s, gate_s, dir_s, pulse_s} = sync_lvl;

    // Software-visible registers.
    logic [31:0]            ctrl_q,   ctrl_d;
    logic [31:0]            lower_q,  lower_d;
    logic [31:0]            upper_q,  upper_d;
    logic [31:0]            period_q, period_d;
    logic [31:0]            gear_q,   gear_d;
    logic [EV_W-1:0]        imask_q,  imask_d;
    logic [EV_W-1:0]        istat_q,  istat_d;
    logic [31:0]            rdat_d;
    logic                   ack_d;
    logic                   irq_d;
    // Counter state.
    logic [CNT_W-1:0]       cnt_q,    cnt_d;
    logic [CNT_W-1:0]       scaled_q, scaled_d;
    logic                   dir_q,    dir_d;
    logic                   plim_q,   plim_d;
    logic                   nlim_q,   nlim_d;
    logic [2:0]             axis_q,   axis_d;
    logic [2:0]             step_q,   step_d;
    logic [STEP_CW-1:0]     stcnt_q,  stcnt_d;
    // Probe outputs.
    logic [CNT_W-1:0]       rise_lat [2];
    logic [CNT_W-1:0]       fall_lat [2];
    logic [1:0]             rise_ev;
    logic [1:0]             fall_ev;
    // Decoded controls.
    logic                   en;
    logic                   ring;
    logic                   lim_en;
    logic [GATES-1:0]       gate_sel;
    logic                   gate_ok;
    logic                   run;
    logic                   step_ev;
    logic                   up;
    logic                   wr_hit;
    logic [31:0]            bmask;
    logic [EV_W-1:0]        ev;
    logic signed [63:0]     prod;

    assign en       = ctrl_q[CTRL_EN_BIT];
    assign ring     = ctrl_q[CTRL_RING_BIT];
    assign lim_en   = ctrl_q[CTRL_LIM_BIT];
    assign gate_sel = ctrl_q[CTRL_GATE_LSB +: GATES];

    // One probe unit per probe pin.
    for (genvar p = 0; p < 2; p++)
    begin : g_probe
        beac_probe u_probe (
            .clk_i        (clk_i),
            .rst_i        (rst_i),
            .level_i      (probe_s[p]),
            .count_i      (cnt_q),
            .rise_latch_o (rise_lat[p]),
            .fall_latch_o (fall_lat[p]),
            .rise_ev_o    (rise_ev[p]),
            .fall_ev_o    (fall_ev[p])
        );
    end

    // Bus decode: writes land on the edge where ack is high, reads are staged a cycle early.
    always_comb
    begin
        wr_hit = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
        ack_d  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
        for (int b = 0; b < 4; b++)
        begin
            bmask[8*b +: 8] = {8{wb_sel_i[b]}};
        end
        ctrl_d   = ctrl_q;
        lower_d  = lower_q;
        upper_d  = upper_q;
        period_d = period_q;
        gear_d   = gear_q;
        imask_d  = imask_q;
        if (wr_hit)
        begin
            case (wb_adr_i)
                OFF_CTRL:     ctrl_d   = (ctrl_q & ~bmask) | (wb_dat_i & bmask);
                OFF_LOWER:    lower_d  = (lower_q & ~bmask) | (wb_dat_i & bmask);
                OFF_UPPER:    upper_d  = (upper_q & ~bmask) | (wb_dat_i & bmask);
                OFF_PERIOD:   period_d = (period_q & ~bmask) | (wb_dat_i & bmask);
                OFF_GEAR:     gear_d   = (gear_q & ~bmask) | (wb_dat_i & bmask);
                OFF_IRQ_MASK: imask_d  = (imask_q & ~bmask[EV_W-1:0]) | (wb_dat_i[EV_W-1:0]
                                         & bmask[EV_W-1:0]);
                default:      ;
            endcase
        end
        rdat_d = '0;
        case (wb_adr_i)
            OFF_CTRL:     rdat_d = ctrl_q;
            OFF_STATUS:
            begin
                rdat_d[ST_DIR_BIT]           = dir_q;
                rdat_d[ST_PLIM_BIT]          = plim_q;
                rdat_d[ST_NLIM_BIT]          = nlim_q;
                rdat_d[ST_AXIS_LSB +: 3]     = axis_q;
                rdat_d[ST_STEP_LSB +: 3]     = step_q;
            end
            OFF_LOWER:    rdat_d = lower_q;
            OFF_UPPER:    rdat_d = upper_q;
            OFF_PERIOD:   rdat_d = period_q;
            OFF_GEAR:     rdat_d = gear_q;
            OFF_RAW:      rdat_d = cnt_q;
            OFF_SCALED:   rdat_d = scaled_q;
            OFF_P1_RISE:  rdat_d = rise_lat[0];
            OFF_P2_RISE:  rdat_d = rise_lat[1];
            OFF_P1_FALL:  rdat_d = fall_lat[0];
            OFF_P2_FALL:  rdat_d = fall_lat[1];
            OFF_IRQ_STAT: rdat_d[EV_W-1:0] = istat_q;
            OFF_IRQ_MASK: rdat_d[EV_W-1:0] = imask_q;
            default:      rdat_d = '0;
        endcase
    end

    // Bus registers; unmapped offsets still answer, reading zero.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_q   <= '0;
            lower_q  <= LOWER_RST;
            upper_q  <= UPPER_RST;
            period_q <= PERIOD_RST;
            gear_q   <= GEAR_RST;
            imask_q  <= '0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end
        else
        begin
            ctrl_q   <= ctrl_d;
            lower_q  <= lower_d;
            upper_q  <= upper_d;
            period_q <= period_d;
            gear_q   <= gear_d;
            imask_q  <= imask_d;
            wb_ack_o <= ack_d;
            wb_dat_o <= ack_d ? rdat_d : wb_dat_o;
        end
    end

    // Counting logic; a step is a rising edge of the settled pulse pin.
    always_comb
    begin
        gate_ok = &(gate_s | ~gate_sel);
        run     = en & gate_ok & (step_q == STEP_READY) & ~fault_s;
        step_ev = pulse_s & ~pulse_prev_q;
        up      = ~dir_s;
        cnt_d   = cnt_q;
        dir_d   = dir_q;
        if (run && step_ev)
        begin
            dir_d = ~up;
            if (ring)
            begin
                if (up)
                    cnt_d = ($signed(cnt_q) >= $signed(period_q - 32'h0000_0001)) ? '0
                            : cnt_q + 32'h0000_0001;
                else
                    cnt_d = ($signed(cnt_q) <= 0) ? period_q - 32'h0000_0001
                            : cnt_q - 32'h0000_0001;
            end
            else if (lim_en)
            begin
                if (up)
                    cnt_d = ($signed(cnt_q) >= $signed(upper_q)) ? upper_q
                            : cnt_q + 32'h0000_0001;
                else
                    cnt_d = ($signed(cnt_q) <= $signed(lower_q)) ? lower_q
                            : cnt_q - 32'h0000_0001;
            end
            else
            begin
                cnt_d = up ? cnt_q + 32'h0000_0001 : cnt_q - 32'h0000_0001;
            end
        end
        plim_d   = ~ring & lim_en & ($signed(cnt_d) >= $signed(upper_q));
        nlim_d   = ~ring & lim_en & ($signed(cnt_d) <= $signed(lower_q));
        prod     = $signed(cnt_q) * $signed(gear_q);
        scaled_d = prod[GEAR_FRAC +: CNT_W];
        if (fault_s)
            axis_d = AXIS_FAULT;
        else if (run)
            axis_d = AXIS_RUN;
        else
            axis_d = AXIS_STOP;
    end

    // Bring-up walks one step per dwell time until the axis is ready.
    always_comb
    begin
        step_d  = step_q;
        stcnt_d = stcnt_q;
        if (step_q != STEP_READY)
        begin
            if (stcnt_q == STEP_CW'(STEP_CYC - 1))
            begin
                stcnt_d = '0;
                step_d  = step_q + 3'h1;
            end
            else
            begin
                stcnt_d = stcnt_q + 1'b1;
            end
        end
    end

    // Interrupt events; a new event beats a clear in the same cycle.
    always_comb
    begin
        ev             = '0;
        ev[EV_P1_RISE] = rise_ev[0];
        ev[EV_P2_RISE] = rise_ev[1];
        ev[EV_P1_FALL] = fall_ev[0];
        ev[EV_P2_FALL] = fall_ev[1];
        ev[EV_PLIM]    = plim_d & ~plim_q;
        ev[EV_NLIM]    = nlim_d & ~nlim_q;
        istat_d        = istat_q;
        if (wr_hit && wb_adr_i == OFF_IRQ_STAT)
            istat_d = istat_q & ~(wb_dat_i[EV_W-1:0] & bmask[EV_W-1:0]);
        istat_d = istat_d | ev;
        irq_d   = |(istat_d & imask_d);
    end

    // Counter, status and interrupt registers.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_q        <= '0;
            scaled_q     <= '0;
            dir_q        <= 1'b0;
            plim_q       <= 1'b0;
            nlim_q       <= 1'b0;
            axis_q       <= AXIS_STOP;
            step_q       <= STEP_INIT;
            stcnt_q      <= '0;
            pulse_prev_q <= 1'b0;
            istat_q      <= '0;
            irq_o        <= 1'b0;
        end
        else
        begin
            cnt_q        <= cnt_d;
            scaled_q     <= scaled_d;
            dir_q        <= dir_d;
            plim_q       <= plim_d;
            nlim_q       <= nlim_d;
            axis_q       <= axis_d;
            step_q       <= step_d;
            stcnt_q      <= stcnt_d;
            pulse_prev_q <= pulse_s;
            istat_q      <= istat_d;
            irq_o        <= irq_d;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_hold_when_off: assert property (!en |=> $stable(cnt_q))
        else $error("count moved while disabled");
    a_gate_blocks:   assert property (!gate_ok |=> $stable(cnt_q))
        else $error("count moved with gate closed");
    a_ring_wrap:     assert property (run && step_ev && up && ring && period_q != 0
                                      && cnt_q == period_q - 32'h0000_0001 |=> cnt_q == 0)
        else $error("ring did not wrap to zero");
    a_limit_clamp:   assert property (run && step_ev && up && !ring && lim_en
                                      && cnt_q == upper_q |=> cnt_q == $past(upper_q))
        else $error("count passed upper limit");
    a_free_wrap:     assert property (run && step_ev && up && !ring && !lim_en
                                      && cnt_q == CNT_MAX |=> cnt_q == CNT_MIN)
        else $error("count did not wrap at maximum");
    a_dir_report:    assert property (run && step_ev |=> dir_q == $past(dir_s))
        else $error("direction bit wrong");
    a_plim_flag:     assert property (plim_q == (!ring && lim_en
                                      && $signed(cnt_q) >= $signed(upper_q)) || $changed(ctrl_q)
                                      || $changed(upper_q))
        else $error("positive limit flag wrong");
    a_nlim_flag:     assert property (nlim_q == (!ring && lim_en
                                      && $signed(cnt_q) <= $signed(lower_q)) || $changed(ctrl_q)
                                      || $changed(lower_q))
        else $error("negative limit flag wrong");
    a_axis_fault:    assert property (fault_s |=> axis_q == AXIS_FAULT)
        else $error("fault code missing");
    a_step_order:    assert property ($changed(step_q) |-> step_q == $past(step_q) + 3'h1)
        else $error("bring-up step skipped");
    a_probe_rise:    assert property (probe_s[0] && !$past(probe_s[0])
                                      |=> rise_lat[0] == $past(cnt_q))
        else $error("probe rise not latched");
endmodule
